// *** logic/iolc_pkg.sv ***
// Purpose: Constants and types for the I/O line drive and function mux block
// Assumes: 32-bit register port, word addresses chosen locally
// Notes:   Offsets are byte addresses, one aligned word each
package iolc_pkg;
   localparam int          IOLC_LINES   = 32;
   localparam int          IOLC_AW      = 8;
   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [7:0]  OFS_OUT_DATA      = 8'h00;
   localparam logic [7:0]  OFS_OD_ENABLE     = 8'h04;
   localparam logic [7:0]  OFS_OD_DISABLE    = 8'h08;
   localparam logic [7:0]  OFS_OD_STATUS     = 8'h0c;
   localparam logic [7:0]  OFS_PU_DISABLE    = 8'h10;
   localparam logic [7:0]  OFS_PU_ENABLE     = 8'h14;
   localparam logic [7:0]  OFS_PU_STATUS     = 8'h18;
   localparam logic [7:0]  OFS_FN_A_SELECT   = 8'h1c;
   localparam logic [7:0]  OFS_FN_B_SELECT   = 8'h20;
   localparam logic [7:0]  OFS_FN_STATUS     = 8'h24;
   localparam logic [7:0]  OFS_OW_ENABLE     = 8'h28;
   localparam logic [7:0]  OFS_OW_DISABLE    = 8'h2c;
   localparam logic [7:0]  OFS_OW_STATUS     = 8'h30;
   localparam logic [7:0]  OFS_OUT_ENABLE    = 8'h34;
   localparam logic [7:0]  OFS_PIO_SELECT    = 8'h38;
   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [31:0] RST_OUT_DATA   = 32'h0000_0000;
   localparam logic [31:0] RST_OPEN_DRAIN = 32'h0000_0000;
   localparam logic [31:0] RST_PULLUP_ON  = 32'hffff_ffff;
   localparam logic [31:0] RST_FN_B       = 32'h0000_0000;
   localparam logic [31:0] RST_OW_ALLOW   = 32'h0000_0000;
   localparam logic [31:0] RST_OUT_ENABLE = 32'h0000_0000;
   localparam logic [31:0] RST_PIO_SEL    = 32'hffff_ffff;
   localparam logic [31:0] RD_UNMAPPED    = 32'h0000_0000;

   typedef struct packed {
      logic [IOLC_AW-1:0] addr;
      logic [31:0]        wdata;
      logic               wr;
      logic               rd;
   } iolc_bus_req_t;

   typedef struct packed {
      logic [31:0] out;
      logic [31:0] oe;
   } iolc_periph_t;
endpackage : iolc_pkg

// *** logic/iolc_top.sv ***
// Notes on behaviour
// - Open-drain enable write: bits at one make those lines open-drain.
// - Open-drain disable write: bits at one return lines to push-pull.
// - Open-drain status reads one for open-drain lines, zero for push-pull.
// - Pull-up disable write: bits at one turn pull-up off.
// - Pull-up enable write: bits at one turn pull-up on.
// - Pull-up status reads zero when enabled, one when disabled.
// - Function A select write: bits at one route line to function A.
// - Function B select write: bits at one route line to function B.
// - Function status reads zero for function A, one for function B.
// - Output-write enable write: bits at one let data writes reach line.
// - Output-write disable write: bits at one block data writes to line.
// - Output-write status reads one where data writes reach the line.
// - Output data holds per-line level: one high, zero low.
//
// Purpose: Per-line drive mode, pull-up, function mux and output data for 32 I/O lines
// Assumes: Single 10 MHz clock; register port answers reads one cycle later
// Notes:   Pin pad is three signals per line; the bench resolves the wire
`timescale 1ns/1ps
`default_nettype none
module iolc_top
   import iolc_pkg::*;
#(
   parameter int LINES = IOLC_LINES
)(
   // Clock and reset
   input  wire logic              sys_clk,
   input  wire logic              resetn,
   // Register port
   input  wire logic [IOLC_AW-1:0] reg_addr,
   input  wire logic [31:0]        reg_wdata,
   input  wire logic               reg_wr,
   input  wire logic               reg_rd,
   output var  logic [31:0]        reg_rdata,
   // Peripheral functions A and B
   input  wire iolc_periph_t       periph_a,
   input  wire iolc_periph_t       periph_b,
   // Pads
   input  wire logic [LINES-1:0]   pad_in,
   output var  logic [LINES-1:0]   pad_out,
   output var  logic [LINES-1:0]   pad_oe,
   output var  logic [LINES-1:0]   pad_pullup_en,
   output var  logic [LINES-1:0]   pad_level_reg
);
   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   iolc_bus_req_t req;
   assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

   wire logic [LINES-1:0] wd = req.wdata[LINES-1:0];
   wire logic wr_data  = req.wr && (req.addr == OFS_OUT_DATA);
   wire logic wr_od_en = req.wr && (req.addr == OFS_OD_ENABLE);
   wire logic wr_od_di = req.wr && (req.addr == OFS_OD_DISABLE);
   wire logic wr_pu_di = req.wr && (req.addr == OFS_PU_DISABLE);
   wire logic wr_pu_en = req.wr && (req.addr == OFS_PU_ENABLE);
   wire logic wr_fn_a  = req.wr && (req.addr == OFS_FN_A_SELECT);
   wire logic wr_fn_b  = req.wr && (req.addr == OFS_FN_B_SELECT);
   wire logic wr_ow_en = req.wr && (req.addr == OFS_OW_ENABLE);
   wire logic wr_ow_di = req.wr && (req.addr == OFS_OW_DISABLE);
   wire logic wr_oe    = req.wr && (req.addr == OFS_OUT_ENABLE);
   wire logic wr_psel  = req.wr && (req.addr == OFS_PIO_SELECT);

   // ------------------------------------------------------------
   // Per-line state
   // ------------------------------------------------------------
   logic [LINES-1:0] open_drain_reg, open_drain_next;
   logic [LINES-1:0] pullup_on_reg,  pullup_on_next;
   logic [LINES-1:0] fn_b_reg,       fn_b_next;
   logic [LINES-1:0] ow_allow_reg,   ow_allow_next;
   logic [LINES-1:0] out_data_reg,   out_data_next;
   logic [LINES-1:0] out_en_reg,     out_en_next;
   logic [LINES-1:0] pio_sel_reg,    pio_sel_next;

   // Set and clear in the same word cannot happen: one strobe per cycle
   assign open_drain_next = wr_od_en ? (open_drain_reg | wd)
                          : wr_od_di ? (open_drain_reg & ~wd)
                          : open_drain_reg;
   assign pullup_on_next  = wr_pu_en ? (pullup_on_reg | wd)
                          : wr_pu_di ? (pullup_on_reg & ~wd)
                          : pullup_on_reg;
   assign fn_b_next       = wr_fn_b ? (fn_b_reg | wd)
                          : wr_fn_a ? (fn_b_reg & ~wd)
                          : fn_b_reg;
   assign ow_allow_next   = wr_ow_en ? (ow_allow_reg | wd)
                          : wr_ow_di ? (ow_allow_reg & ~wd)
                          : ow_allow_reg;
   // Masked direct write: only permitted lines take the new level
   assign out_data_next   = wr_data
                          ? ((out_data_reg & ~ow_allow_reg) | (wd & ow_allow_reg))
                          : out_data_reg;
   assign out_en_next     = wr_oe   ? wd : out_en_reg;
   assign pio_sel_next    = wr_psel ? wd : pio_sel_reg;

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         open_drain_reg <= RST_OPEN_DRAIN[LINES-1:0];
         pullup_on_reg  <= RST_PULLUP_ON[LINES-1:0];
         fn_b_reg       <= RST_FN_B[LINES-1:0];
         ow_allow_reg   <= RST_OW_ALLOW[LINES-1:0];
         out_data_reg   <= RST_OUT_DATA[LINES-1:0];
         out_en_reg     <= RST_OUT_ENABLE[LINES-1:0];
         pio_sel_reg    <= RST_PIO_SEL[LINES-1:0];
      end
      else
      begin
         open_drain_reg <= open_drain_next;
         pullup_on_reg  <= pullup_on_next;
         fn_b_reg       <= fn_b_next;
         ow_allow_reg   <= ow_allow_next;
         out_data_reg   <= out_data_next;
         out_en_reg     <= out_en_next;
         pio_sel_reg    <= pio_sel_next;
      end
   end

   // ------------------------------------------------------------
   // Pad drive
   // ------------------------------------------------------------
   logic [LINES-1:0] lvl, drv_en, oe_next, out_next;
   genvar g;
   generate
      for (g = 0; g < LINES; g++)
      begin : g_line
         assign lvl[g]    = pio_sel_reg[g] ? out_data_reg[g]
                          : (fn_b_reg[g] ? periph_b.out[g] : periph_a.out[g]);
         assign drv_en[g] = pio_sel_reg[g] ? out_en_reg[g]
                          : (fn_b_reg[g] ? periph_b.oe[g] : periph_a.oe[g]);
         // Open-drain lines only pull low; a high is a release
         assign oe_next[g]  = drv_en[g] && !(open_drain_reg[g] && lvl[g]);
         assign out_next[g] = lvl[g];
      end
   endgenerate

   // ------------------------------------------------------------
   // Read mux
   // ------------------------------------------------------------
   logic [31:0] rd_word;
   logic [31:0] rd_next;
   always_comb
   begin
      rd_word = RD_UNMAPPED;
      case (req.addr)
         OFS_OUT_DATA:   rd_word[LINES-1:0] = out_data_reg;
         OFS_OD_STATUS:  rd_word[LINES-1:0] = open_drain_reg;
         OFS_PU_STATUS:  rd_word[LINES-1:0] = ~pullup_on_reg;
         OFS_FN_STATUS:  rd_word[LINES-1:0] = fn_b_reg;
         OFS_OW_STATUS:  rd_word[LINES-1:0] = ow_allow_reg;
         OFS_OUT_ENABLE: rd_word[LINES-1:0] = out_en_reg;
         OFS_PIO_SELECT: rd_word[LINES-1:0] = pio_sel_reg;
         default:        rd_word = RD_UNMAPPED;
      endcase
   end
   // Data stand only in the cycle after the read strobe
   assign rd_next = req.rd ? rd_word : RD_UNMAPPED;

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         reg_rdata     <= RD_UNMAPPED;
         pad_out       <= '0;
         pad_oe        <= '0;
         pad_pullup_en <= '0;
         pad_level_reg <= '0;
      end
      else
      begin
         reg_rdata     <= rd_next;
         pad_out       <= out_next;
         pad_oe        <= oe_next;
         pad_pullup_en <= pullup_on_reg;
         pad_level_reg <= pad_in;
      end
   end
endmodule // iolc_top
`default_nettype wire

// *** verif/iolc_pad_model.sv ***
// Purpose: Pad-side model resolving each line from drive, enable and pull-up
// Assumes: One level per line, no outside driver
// Notes:   Undriven lines without pull-up toggle every cycle
`timescale 1ns/1ps
`default_nettype none
module iolc_pad_model (
   // Clock
   input  wire logic        sys_clk,
   // Pad drive from the block
   input  wire logic [31:0] pad_out,
   input  wire logic [31:0] pad_oe,
   input  wire logic [31:0] pad_pullup_en,
   // Resolved level
   output wire logic [31:0] pad_in
);
   logic [31:0] float_pat = 32'h5555_5555;
   // Floating lines wander, so a stale level never passes for a real one
   always @(posedge sys_clk) float_pat <= ~float_pat;
   assign pad_in = (pad_oe & pad_out) | (~pad_oe & (pad_pullup_en | float_pat));
endmodule // iolc_pad_model
`default_nettype wire

// *** verif/iolc_top_assertions.sv ***
// Purpose: Port-level checker for the I/O line configuration block
// Assumes: Pads follow the state registers by one edge
// Notes:   Bound into every instance of the top module
`timescale 1ns/1ps
`default_nettype none
module iolc_top_assertions
   import iolc_pkg::*;
#(
   parameter int LINES = IOLC_LINES
)(
   // Clock and reset
   input wire logic               sys_clk,
   input wire logic               resetn,
   // Register port
   input wire logic [IOLC_AW-1:0] reg_addr,
   input wire logic [31:0]        reg_wdata,
   input wire logic               reg_wr,
   input wire logic               reg_rd,
   input wire logic [31:0]        reg_rdata,
   // Pads
   input wire logic [LINES-1:0]   pad_out,
   input wire logic [LINES-1:0]   pad_oe,
   input wire logic [LINES-1:0]   pad_pullup_en
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   wire logic [LINES-1:0] wd    = reg_wdata[LINES-1:0];
   wire logic             pu_wr = reg_wr && (reg_addr == OFS_PU_ENABLE || reg_addr == OFS_PU_DISABLE);
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
      else $error("read data outside the answer cycle");
   a_pu_enable: assert property (reg_wr && reg_addr == OFS_PU_ENABLE |=> ##1 (pad_pullup_en & $past(wd, 2)) == $past(wd, 2))
      else $error("pull-up not turned on");
   a_pu_disable: assert property (reg_wr && reg_addr == OFS_PU_DISABLE |=> ##1 (pad_pullup_en & $past(wd, 2)) == '0)
      else $error("pull-up not turned off");
   a_pu_status: assert property (reg_rd && reg_addr == OFS_PU_STATUS |=> reg_rdata[LINES-1:0] == ~pad_pullup_en)
      else $error("pull-up status not inverted");
   a_pu_cause: assert property ($past(resetn, 3) && $changed(pad_pullup_en) |-> $past(pu_wr, 2))
      else $error("pull-up changed without a write");
   a_pu_ro: assert property (reg_wr && reg_addr == OFS_PU_STATUS |=> ##1 $stable(pad_pullup_en))
      else $error("status write changed pull-up");
   a_od_low: assert property (reg_wr && reg_addr == OFS_OD_ENABLE |=> ##1 (pad_oe & pad_out & $past(wd, 2)) == '0)
      else $error("open-drain line driven high");
   a_unmapped_zero: assert property (reg_rd && reg_addr == 8'h3c |=> reg_rdata == RD_UNMAPPED)
      else $error("unmapped read not zero");
endmodule // iolc_top_assertions
bind iolc_top iolc_top_assertions #(.LINES(LINES)) chk (.sys_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr,
   .reg_rd, .reg_rdata, .pad_out, .pad_oe, .pad_pullup_en);
`default_nettype wire

// *** verif/testbench.sv ***
// Purpose: Self-checking bench for the I/O line configuration block
// Assumes: Reads answer one cycle after the strobe
// Notes:   Scenarios share state and run in a fixed order
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import iolc_pkg::*;
   logic          sys_clk = 1'b0;
   logic          resetn  = 1'b0;
   iolc_bus_req_t bus     = '0;
   iolc_periph_t  per_a   = '0;
   iolc_periph_t  per_b   = '0;
   logic [31:0]   rdata, pad_in, pad_out, pad_oe, pad_pu, pad_lvl;
   int            n_mismatch  = 0;
   int            comparisons = 0;
   int            cycles      = 0;
   always #50 sys_clk = ~sys_clk;
   iolc_top uut (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(bus.addr), .reg_wdata(bus.wdata),
      .reg_wr(bus.wr), .reg_rd(bus.rd), .reg_rdata(rdata), .periph_a(per_a), .periph_b(per_b),
      .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup_en(pad_pu), .pad_level_reg(pad_lvl));
   iolc_pad_model pads (.sys_clk(sys_clk), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup_en(pad_pu),
      .pad_in(pad_in));
   task automatic stop_test;
      $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         n_mismatch++;
         stop_test;
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Strobe stays up so writes can follow each other with no gap
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk);
      bus <= '0;
      #1 chk(rdata, exp);
      @(posedge sys_clk);
   endtask
   task automatic t_reset;
      rd(OFS_OD_STATUS, RST_OPEN_DRAIN);
      rd(OFS_PU_STATUS, ~RST_PULLUP_ON);
      rd(OFS_FN_STATUS, RST_FN_B);
      rd(OFS_OW_STATUS, RST_OW_ALLOW);
      rd(8'h3c, RD_UNMAPPED);
   endtask
   task automatic t_ow;
      wr(OFS_OW_ENABLE, 32'h0000_00ff);
      wr(OFS_OW_DISABLE, 32'h0000_000f);
      rd(OFS_OW_STATUS, 32'h0000_00f0);
      wr(OFS_OW_STATUS, 32'hffff_ffff);
      wr(OFS_OUT_DATA, 32'hffff_ffff);
      rd(OFS_OUT_DATA, 32'h0000_00f0);
      rd(OFS_OW_STATUS, 32'h0000_00f0);
   endtask
   task automatic t_od;
      wr(OFS_OUT_ENABLE, 32'h0000_00f0);
      wr(OFS_OD_ENABLE, 32'h0000_00ff);
      wr(OFS_OD_DISABLE, 32'h0000_00cf);
      rd(OFS_OD_STATUS, 32'h0000_0030);
      #1 chk(pad_oe & 32'h0000_00f0, 32'h0000_00c0);
      chk(pad_out & 32'h0000_00c0, 32'h0000_00c0);
      chk(pad_in & 32'h0000_00f0, 32'h0000_00f0);
      chk(pad_lvl & 32'h0000_00f0, 32'h0000_00f0);
      @(posedge sys_clk);
   endtask
   task automatic t_pu;
      wr(OFS_PU_DISABLE, 32'h0000_ffff);
      wr(OFS_PU_ENABLE, 32'h0000_00ff);
      wr(OFS_PU_STATUS, 32'hffff_ffff);
      rd(OFS_PU_STATUS, 32'h0000_ff00);
      #1 chk(pad_pu, 32'hffff_00ff);
      @(posedge sys_clk);
   endtask
   task automatic t_fn;
      wr(OFS_FN_B_SELECT, 32'ha5a5_a5a5);
      wr(OFS_FN_A_SELECT, 32'h0000_00ff);
      rd(OFS_FN_STATUS, 32'ha5a5_a500);
      per_a <= '{out: 32'h0, oe: 32'hffff_ffff};
      per_b <= '{out: 32'hffff_ffff, oe: 32'hffff_ffff};
      wr(OFS_PIO_SELECT, 32'hffff_fcff);
      bus <= '0;
      repeat (3) @(posedge sys_clk);
      #1 chk(pad_out & 32'h0000_0300, 32'h0000_0100);
      chk(pad_oe & 32'h0000_0300, 32'h0000_0300);
   endtask
   // Mid-run reset must bring the open-drain, pull-up, function and output-write state back
   task automatic t_rst;
      @(posedge sys_clk);
      resetn <= 1'b0;
      repeat (3) @(posedge sys_clk);
      resetn <= 1'b1;
      @(posedge sys_clk);
      t_reset;
      #1 chk(pad_pu, RST_PULLUP_ON);
   endtask
   initial
   begin
      repeat (16) @(posedge sys_clk);
      resetn <= 1'b1;
      @(posedge sys_clk);
      t_reset;
      t_ow;
      t_od;
      t_pu;
      t_fn;
      t_rst;
      stop_test;
   end
endmodule // testbench
`default_nettype wire
